// ### core/sdcd_mem_end.sv
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
// Operation
// - Decode strobes and clock enable at edge
// - Address widths follow configured density
// - Controller keeps reset pin high unless memResetReq is set
// - Mode register set selects register by bank
// - Activate row in addressed bank
// - Write burst at column, upper bits reserved
// - Read burst at column and bank
// - On-the-fly chop bit: low four, high eight
// - Auto precharge bit closes bank
// - Burst mode from mode register, never interrupted
// - No operation lets bursts continue
// - Deselect acts as no operation
// - Clock enable edges enter and leave power-down
// - Self refresh entry and exit
// - Termination follows the bus control, disabled in self refresh
// - Controller waits 512 cycles after each clock enable rise before writes
// - Controller drives defined levels
module sdcd_mem_end #(
    parameter int BANK_W = 3,
    parameter int ADDR_W = 15,
    parameter int ROW_W = 15,
    parameter int COL_W = 10
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Link
    sdcd_bus_if.memory bus,
    // Decoded command
    output sdcd_pkg::sdcd_cmd_type cmdOut,
    output logic cmdStrobe,
    output logic [BANK_W-1:0] cmdBank,
    output logic [ROW_W-1:0] cmdRow,
    output logic [COL_W-1:0] cmdCol,
    output logic [ADDR_W-1:0] cmdOpcode,
    output logic autoPrecharge,
    output logic [3:0] burstBeats,
    // State
    output sdcd_pkg::sdcd_state_type powerState,
    output logic burstBusy,
    output logic terminationEnable,
    output logic [1:0] burstMode
);
    sdcd_pkg::sdcd_cmd_type cmd_d, cmd_q;
    sdcd_pkg::sdcd_state_type st_d, st_q;
    logic ckePrev_q, stb_q, ap_q, term_q;
    logic [BANK_W-1:0] bank_q;
    logic [ROW_W-1:0] row_q;
    logic [COL_W-1:0] col_q;
    logic [ADDR_W-1:0] op_q;
    logic [3:0] beats_q, left_q;
    logic [1:0] blMode_q;
    // ****
    // Command decode
    // ****
    // Command pattern
    wire [3:0] pat = {bus.csN, bus.rasN, bus.casN, bus.weN};
    wire ckeHH = ckePrev_q && bus.cke;
    wire ckeHL = ckePrev_q && !bus.cke;
    wire ckeLH = !ckePrev_q && bus.cke;
    wire idleCmd = bus.csN || (pat == 4'h7);
    wire apBit = bus.addr[`SDCD_AP_BIT];
    wire bcBit = bus.addr[`SDCD_BC_BIT];
    wire isRw = ckeHH && (pat == 4'h4 || pat == 4'h5);
    // Burst mode chosen by mode register
    wire flyMode = (blMode_q == `SDCD_BL_FLY);
    wire [3:0] beatsSel = flyMode ? (bcBit ? `SDCD_BEATS8 : `SDCD_BEATS4)
        : ((blMode_q == `SDCD_BL_FIXED4) ? `SDCD_BEATS4 : `SDCD_BEATS8);
    wire mrsBurst = ckeHH && pat == 4'h0 && bus.bank == BANK_W'(`SDCD_MR_BURST);
    // ****
    // Power state machine
    // ****
    always_comb
    begin
        cmd_d = sdcd_pkg::CMD_NONE;
        st_d = st_q;
        case (st_q)
            sdcd_pkg::ST_IDLE:
            begin
                if (ckeHL && pat == 4'h1)
                begin
                    cmd_d = sdcd_pkg::CMD_SELF_REFRESH_ENTRY;
                    st_d = sdcd_pkg::ST_SELF_REFRESH;
                end
                else if (ckeHL && idleCmd)
                begin
                    cmd_d = sdcd_pkg::CMD_POWER_DOWN_ENTRY;
                    st_d = sdcd_pkg::ST_POWER_DOWN;
                end
                else if (!ckeHH || idleCmd)
                    cmd_d = ckeHH ? sdcd_pkg::CMD_NO_OPERATION : sdcd_pkg::CMD_NONE;
                else
                begin
                    case (pat)
                        4'h0: cmd_d = sdcd_pkg::CMD_MODE_SET;
                        4'h1: cmd_d = sdcd_pkg::CMD_REFRESH;
                        4'h2: cmd_d = apBit ? sdcd_pkg::CMD_PRECHARGE_ALL
                            : sdcd_pkg::CMD_PRECHARGE;
                        4'h3: cmd_d = sdcd_pkg::CMD_ACTIVATE;
                        4'h4: cmd_d = sdcd_pkg::CMD_WRITE;
                        4'h5: cmd_d = sdcd_pkg::CMD_READ;
                        4'h6: cmd_d = apBit ? sdcd_pkg::CMD_CAL_LONG : sdcd_pkg::CMD_CAL_SHORT;
                        default: cmd_d = sdcd_pkg::CMD_NONE;
                    endcase
                end
            end
            sdcd_pkg::ST_POWER_DOWN:
            begin
                if (ckeLH && idleCmd)
                begin
                    cmd_d = sdcd_pkg::CMD_POWER_DOWN_EXIT;
                    st_d = sdcd_pkg::ST_IDLE;
                end
            end
            sdcd_pkg::ST_SELF_REFRESH:
            begin
                if (ckeLH && idleCmd)
                begin
                    cmd_d = sdcd_pkg::CMD_SELF_REFRESH_EXIT;
                    st_d = sdcd_pkg::ST_IDLE;
                end
            end
            default: st_d = sdcd_pkg::ST_IDLE;
        endcase
    end
    // ****
    // Registers
    // ****
    // Bus reset pin acts on the clock edge; an asynchronous path is not modelled
    always_ff @(posedge core_clk)
    begin
        if (!resetn || !bus.resetN)
        begin
            ckePrev_q <= 1'b0;
            st_q <= sdcd_pkg::ST_IDLE;
            cmd_q <= sdcd_pkg::CMD_NONE;
            stb_q <= 1'b0;
            bank_q <= '0;
            row_q <= '0;
            col_q <= '0;
            op_q <= '0;
            ap_q <= 1'b0;
            beats_q <= '0;
            left_q <= '0;
            blMode_q <= `SDCD_BL_FIXED8;
            term_q <= 1'b0;
        end
        else if (clkEn)
        begin
            ckePrev_q <= bus.cke;
            st_q <= st_d;
            cmd_q <= cmd_d;
            stb_q <= (cmd_d != sdcd_pkg::CMD_NONE);
            if (cmd_d != sdcd_pkg::CMD_NONE && cmd_d != sdcd_pkg::CMD_NO_OPERATION)
            begin
                bank_q <= bus.bank;
                row_q <= bus.addr[ROW_W-1:0];
                col_q <= bus.addr[COL_W-1:0];
                op_q <= bus.addr;
            end
            ap_q <= isRw && apBit;
            beats_q <= isRw ? beatsSel : 4'h0;
            if (mrsBurst)
                blMode_q <= bus.addr[`SDCD_BL_HI:`SDCD_BL_LO];
            if (isRw && left_q == 4'h0)
                left_q <= beatsSel;
            else if (left_q != 4'h0)
                left_q <= left_q - 4'h1;
            term_q <= bus.terminationControl && (st_d != sdcd_pkg::ST_SELF_REFRESH);
        end
    end
    // ****
    // Outputs
    // ****
    assign cmdOut = cmd_q;
    assign cmdStrobe = stb_q;
    assign cmdBank = bank_q;
    assign cmdRow = row_q;
    assign cmdCol = col_q;
    assign cmdOpcode = op_q;
    assign autoPrecharge = ap_q;
    assign burstBeats = beats_q;
    assign powerState = st_q;
    assign burstBusy = (left_q != 4'h0);
    assign terminationEnable = term_q;
    assign burstMode = blMode_q;
endmodule : sdcd_mem_end

// ### core/sdcd_cfg.svh
`ifndef SDCD_CFG_SVH
`define SDCD_CFG_SVH
// Command field positions on the address bus
`define SDCD_AP_BIT 10
`define SDCD_BC_BIT 12
// Mode register index holding burst length setting
`define SDCD_MR_BURST 3'h0
// Burst length field values in mode register 0
`define SDCD_BL_FIXED8 2'h0
`define SDCD_BL_FLY 2'h1
`define SDCD_BL_FIXED4 2'h2
// Burst length field position in mode register 0
`define SDCD_BL_HI 1
`define SDCD_BL_LO 0
// Beat counts
`define SDCD_BEATS8 4'h8
`define SDCD_BEATS4 4'h4
// Self-refresh exit guard
`define SDCD_SRX_GUARD_NCK 512
`endif

// ### core/sdcd_pkg.sv
package sdcd_pkg;
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_MODE_SET = 4'h1,
        CMD_REFRESH = 4'h2,
        CMD_SELF_REFRESH_ENTRY = 4'h3,
        CMD_SELF_REFRESH_EXIT = 4'h4,
        CMD_PRECHARGE = 4'h5,
        CMD_PRECHARGE_ALL = 4'h6,
        CMD_ACTIVATE = 4'h7,
        CMD_WRITE = 4'h8,
        CMD_READ = 4'h9,
        CMD_NO_OPERATION = 4'ha,
        CMD_POWER_DOWN_ENTRY = 4'hb,
        CMD_POWER_DOWN_EXIT = 4'hc,
        CMD_CAL_LONG = 4'hd,
        CMD_CAL_SHORT = 4'he
    } sdcd_cmd_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POWER_DOWN = 2'b01,
        ST_SELF_REFRESH = 2'b10
    } sdcd_state_type;
endpackage : sdcd_pkg

// ### core/sdcd_bus_if.sv
`timescale 1ns/1ps
interface sdcd_bus_if #(
    parameter int BANK_W = 3,
    parameter int ADDR_W = 15
);
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic terminationControl;
    logic resetN;
    modport controller (output cke, csN, rasN, casN, weN, bank, addr, terminationControl, resetN);
    modport memory (input cke, csN, rasN, casN, weN, bank, addr, terminationControl, resetN);
endinterface : sdcd_bus_if

// ### core/sdcd_ctrl_end.sv
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
module sdcd_ctrl_end #(
    parameter int BANK_W = 3,
    parameter int ADDR_W = 15
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // User command
    input wire logic cmdValid,
    input wire logic cmdCke,
    input wire logic cmdCsN,
    input wire logic cmdRasN,
    input wire logic cmdCasN,
    input wire logic cmdWeN,
    input wire logic [BANK_W-1:0] cmdBank,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic cmdTermination,
    input wire logic memResetReq,
    output logic writeAllowed,
    // Link
    sdcd_bus_if.controller bus
);
    localparam int GW = 10;
    localparam logic [GW-1:0] GUARD = GW'(`SDCD_SRX_GUARD_NCK);
    logic ckeQ, csNQ, rasNQ, casNQ, weNQ, termQ, rstNQ, wrOkQ;
    logic [BANK_W-1:0] bankQ;
    logic [ADDR_W-1:0] addrQ;
    logic [GW-1:0] guardQ;
    // Clock enable rise in the user command, driven onto the bus this edge
    wire srxSeen = cmdValid && !ckeQ && cmdCke;
    wire guardDone = (guardQ == GUARD);
    // ****
    // Bus registers
    // ****
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ckeQ <= 1'b1;
            csNQ <= 1'b0;
            rasNQ <= 1'b1;
            casNQ <= 1'b1;
            weNQ <= 1'b1;
            bankQ <= '0;
            addrQ <= '0;
            termQ <= 1'b0;
            rstNQ <= 1'b1;
            guardQ <= GUARD;
            wrOkQ <= 1'b1;
        end
        else if (clkEn)
        begin
            rstNQ <= !memResetReq;
            termQ <= cmdTermination;
            if (cmdValid)
            begin
                ckeQ <= cmdCke;
                csNQ <= cmdCsN;
                rasNQ <= cmdRasN;
                casNQ <= cmdCasN;
                weNQ <= cmdWeN;
                bankQ <= cmdBank;
                addrQ <= cmdAddr;
            end
            else
            begin
                csNQ <= 1'b0;
                rasNQ <= 1'b1;
                casNQ <= 1'b1;
                weNQ <= 1'b1;
            end
            if (srxSeen)
                guardQ <= '0;
            else if (!guardDone)
                guardQ <= guardQ + GW'(1);
            wrOkQ <= guardDone && !srxSeen;
        end
    end
    // ****
    // Bus outputs
    // ****
    assign writeAllowed = wrOkQ;
    assign bus.cke = ckeQ;
    assign bus.csN = csNQ;
    assign bus.rasN = rasNQ;
    assign bus.casN = casNQ;
    assign bus.weN = weNQ;
    assign bus.bank = bankQ;
    assign bus.addr = addrQ;
    assign bus.terminationControl = termQ;
    assign bus.resetN = rstNQ;
endmodule : sdcd_ctrl_end

// ### dv/sdcd_props.sv
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
// ****
// Decode checks
// ****
module sdcd_props #(
    parameter int BANK_W = 3,
    parameter int ADDR_W = 15,
    parameter int ROW_W = 15
) (
    // Clock, reset
    input wire logic core_clk,
    input wire logic resetn,
    // Bus
    input wire logic resetN,
    input wire logic cke,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_W-1:0] addr,
    // Decoder
    input sdcd_pkg::sdcd_cmd_type cmdOut,
    input wire logic [BANK_W-1:0] cmdBank,
    input wire logic [ROW_W-1:0] cmdRow,
    input wire logic [ADDR_W-1:0] cmdOpcode,
    input wire logic autoPrecharge,
    input wire logic [3:0] burstBeats,
    input sdcd_pkg::sdcd_state_type powerState,
    input wire logic burstBusy,
    input wire logic terminationEnable,
    input wire logic [1:0] burstMode
);
    // Mirrors the decoder: first cke after reset is not a held high
    logic ckeQ;
    always_ff @(posedge core_clk)
    begin
        ckeQ <= (resetn && resetN) ? cke : 1'b0;
    end
    wire [3:0] pat = {csN, rasN, casN, weN};
    wire idle = powerState == sdcd_pkg::ST_IDLE;
    wire hh = ckeQ && cke && idle;
    wire rw = hh && pat[3:1] == 3'b010;
    wire down = ckeQ && !cke && idle;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn || !resetN);
    a_mode_set:
    assert property (hh && pat == 4'h0 |=> cmdOut == sdcd_pkg::CMD_MODE_SET
        && cmdOpcode == $past(addr) && cmdBank == $past(bank)) else $error("bad mode set");
    a_refresh_decode:
    assert property (hh && pat == 4'h1 |=> cmdOut == sdcd_pkg::CMD_REFRESH)
        else $error("bad refresh");
    a_activate_row:
    assert property (hh && pat == 4'h3 |=> cmdOut == sdcd_pkg::CMD_ACTIVATE
        && cmdRow == $past(addr)) else $error("bad activate");
    a_write_fields:
    assert property (rw && !weN |=> cmdOut == sdcd_pkg::CMD_WRITE && cmdBank == $past(bank)
        && autoPrecharge == $past(addr[10])) else $error("bad write");
    a_read_fields:
    assert property (rw && weN |=> cmdOut == sdcd_pkg::CMD_READ
        && autoPrecharge == $past(addr[10])) else $error("bad read");
    a_fly_beats:
    assert property (rw && burstMode == `SDCD_BL_FLY |=> burstBeats ==
        ($past(addr[12]) ? `SDCD_BEATS8 : `SDCD_BEATS4)) else $error("bad beats");
    a_precharge_pick:
    assert property (hh && pat == 4'h2 |=> cmdOut == ($past(addr[10]) ?
        sdcd_pkg::CMD_PRECHARGE_ALL : sdcd_pkg::CMD_PRECHARGE)) else $error("bad precharge");
    a_cal_pick:
    assert property (hh && pat == 4'h6 |=> cmdOut == ($past(addr[10]) ?
        sdcd_pkg::CMD_CAL_LONG : sdcd_pkg::CMD_CAL_SHORT)) else $error("bad calibration");
    a_burst_whole:
    assert property ($rose(burstBusy) |-> burstBusy [*4]) else $error("burst cut short");
    a_pd_entry:
    assert property (down && (csN || pat == 4'h7) |=> powerState == sdcd_pkg::ST_POWER_DOWN)
        else $error("no power-down");
    a_sr_entry:
    assert property (down && pat == 4'h1 |=> powerState == sdcd_pkg::ST_SELF_REFRESH)
        else $error("no self refresh");
    a_sr_odt_off:
    assert property (powerState == sdcd_pkg::ST_SELF_REFRESH && $past(powerState) ==
        sdcd_pkg::ST_SELF_REFRESH |-> !terminationEnable) else $error("odt in self refresh");
    cover property (rw);
    cover property ($rose(burstBusy));
    cover property (powerState == sdcd_pkg::ST_SELF_REFRESH);
endmodule : sdcd_props

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "sdcd_cfg.svh"
// ****
// Decoder bench
// ****
module testbench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdCke = 1'b1;
    logic memResetReq = 1'b0;
    logic [3:0] p = 4'hf;
    logic [2:0] cmdBank = 3'h0;
    logic [14:0] cmdAddr = 15'h0000;
    logic writeAllowed, cmdStrobe, autoPrecharge, burstBusy, terminationEnable;
    logic [2:0] oBank;
    logic [14:0] oRow, oOp;
    logic [9:0] oCol;
    logic [3:0] burstBeats;
    logic [1:0] burstMode;
    sdcd_pkg::sdcd_cmd_type cmdOut;
    sdcd_pkg::sdcd_state_type powerState;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    sdcd_bus_if bus ();
    sdcd_ctrl_end sdcd_ctrl_end_i (.core_clk(core_clk), .resetn(resetn), .clkEn(1'b1),
        .cmdValid(cmdValid), .cmdCke(cmdCke), .cmdCsN(p[3]), .cmdRasN(p[2]), .cmdCasN(p[1]),
        .cmdWeN(p[0]), .cmdBank(cmdBank), .cmdAddr(cmdAddr), .cmdTermination(1'b1),
        .memResetReq(memResetReq), .writeAllowed(writeAllowed), .bus(bus));
    sdcd_mem_end sdcd_mem_end_i (.core_clk(core_clk), .resetn(resetn), .clkEn(1'b1),
        .bus(bus), .cmdOut(cmdOut), .cmdStrobe(cmdStrobe), .cmdBank(oBank), .cmdRow(oRow),
        .cmdCol(oCol), .cmdOpcode(oOp), .autoPrecharge(autoPrecharge), .burstBeats(burstBeats),
        .powerState(powerState), .burstBusy(burstBusy), .terminationEnable(terminationEnable),
        .burstMode(burstMode));
    sdcd_props sdcd_props_i (.core_clk(core_clk), .resetn(resetn), .resetN(bus.resetN),
        .cke(bus.cke), .csN(bus.csN), .rasN(bus.rasN), .casN(bus.casN), .weN(bus.weN),
        .bank(bus.bank), .addr(bus.addr), .cmdOut(cmdOut), .cmdBank(oBank), .cmdRow(oRow),
        .cmdOpcode(oOp), .autoPrecharge(autoPrecharge), .burstBeats(burstBeats),
        .powerState(powerState), .burstBusy(burstBusy), .terminationEnable(terminationEnable),
        .burstMode(burstMode));
    initial forever #5 core_clk = ~core_clk;
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    // Decoded result stands one cycle, sampled just after it lands
    task send(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdCke <= k;
        p <= c;
        cmdBank <= b;
        cmdAddr <= a;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : send
    task t_mode;
        send(1, 4'h0, 3'h2, 15'h1234);
        chk("mode", sdcd_pkg::CMD_MODE_SET, cmdOut);
        chk("mrbank", 3'h2, oBank);
        chk("opcode", 15'h1234, oOp);
        chk("stb", 1'b1, cmdStrobe);
        chk("odton", 1'b1, terminationEnable);
    endtask : t_mode
    task t_fly;
        send(1, 4'h0, 3'h0, 15'h0001);
        chk("bmode", 2'h1, burstMode);
        for (int i = 0; i < 8; i++)
        begin
            repeat (6) @(posedge core_clk);
            send(1, {3'b010, i[2]}, i[2:0], {2'b00, i[1], 1'b0, i[0], 10'h155});
            chk("kind", i[2] ? sdcd_pkg::CMD_READ : sdcd_pkg::CMD_WRITE, cmdOut);
            chk("ap", i[0], autoPrecharge);
            chk("beats", i[1] ? 4'h8 : 4'h4, burstBeats);
            chk("col", 10'h155, oCol);
            chk("bank", i[2:0], oBank);
            chk("busy", 1'b1, burstBusy);
        end
    endtask : t_fly
    task t_fixed;
        for (int j = 0; j < 2; j++)
        begin
            send(1, 4'h0, 3'h0, j ? 15'h0000 : 15'h0002);
            repeat (6) @(posedge core_clk);
            send(1, 4'h4, 3'h1, {2'b00, !j[0], 12'h000});
            chk("fixbeats", j ? 4'h8 : 4'h4, burstBeats);
        end
    endtask : t_fixed
    task t_misc;
        send(1, 4'h3, 3'h6, 15'h5a5a);
        chk("act", sdcd_pkg::CMD_ACTIVATE, cmdOut);
        chk("row", 15'h5a5a, oRow);
        send(1, 4'h2, 3'h0, 15'h0400);
        chk("precharge_all_banks", sdcd_pkg::CMD_PRECHARGE_ALL, cmdOut);
        send(1, 4'h2, 3'h3, 15'h0000);
        chk("pre", sdcd_pkg::CMD_PRECHARGE, cmdOut);
        send(1, 4'h6, 3'h0, 15'h0400);
        chk("cal", sdcd_pkg::CMD_CAL_LONG, cmdOut);
        send(1, 4'h6, 3'h0, 15'h0000);
        chk("cal", sdcd_pkg::CMD_CAL_SHORT, cmdOut);
        send(1, 4'h1, 3'h0, 15'h0000);
        chk("ref", sdcd_pkg::CMD_REFRESH, cmdOut);
        send(1, 4'hc, 3'h5, 15'h7fff);
        chk("des", sdcd_pkg::CMD_NO_OPERATION, cmdOut);
    endtask : t_misc
    task t_power;
        send(0, 4'h7, 3'h0, 15'h0000);
        chk("pde", sdcd_pkg::ST_POWER_DOWN, powerState);
        send(0, 4'h4, 3'h0, 15'h0000);
        chk("pdwr", sdcd_pkg::CMD_NONE, cmdOut);
        chk("pdhold", sdcd_pkg::ST_POWER_DOWN, powerState);
        send(1, 4'h7, 3'h0, 15'h0000);
        chk("pdx", sdcd_pkg::ST_IDLE, powerState);
    endtask : t_power
    task t_self;
        send(0, 4'h1, 3'h0, 15'h0000);
        chk("sre", sdcd_pkg::ST_SELF_REFRESH, powerState);
        @(posedge core_clk);
        #1;
        chk("odt", 1'b0, terminationEnable);
        send(1, 4'hf, 3'h0, 15'h0000);
        chk("srx", sdcd_pkg::ST_IDLE, powerState);
        chk("wrhold", 1'b0, writeAllowed);
        repeat (500) @(posedge core_clk);
        #1;
        chk("wrwait", 1'b0, writeAllowed);
        repeat (20) @(posedge core_clk);
        #1;
        chk("wrok", 1'b1, writeAllowed);
    endtask : t_self
    // Mid-run reset through the bus reset pin
    task t_reset;
        send(1, 4'h0, 3'h0, 15'h0002);
        chk("bmode4", `SDCD_BL_FIXED4, burstMode);
        @(posedge core_clk);
        memResetReq <= 1'b1;
        @(posedge core_clk);
        memResetReq <= 1'b0;
        #1;
        chk("rstlow", 1'b0, bus.resetN);
        @(posedge core_clk);
        #1;
        chk("rsthigh", 1'b1, bus.resetN);
        chk("rstmode", `SDCD_BL_FIXED8, burstMode);
        chk("rststate", sdcd_pkg::ST_IDLE, powerState);
    endtask : t_reset
    task results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // Whole run is near 670 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            results();
        end
    end
    initial
    begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_mode();
        t_fly();
        t_fixed();
        t_misc();
        t_power();
        t_self();
        t_reset();
        results();
    end
endmodule : testbench
